// File: rtl/asr_pkg.sv
`default_nettype none
package asr_pkg;
    // address and data widths of the memory outside
    localparam int unsigned ADDR_W      = 16;          // 64K one-bit words
    localparam int unsigned CLK_PS      = 10000;       // clock period, ps (100 MHz)
    // timing of the slowest supported grade, in ns
    localparam int unsigned T_RC_NS     = 35;          // read cycle time
    localparam int unsigned T_AA_NS     = 35;          // address access time
    localparam int unsigned T_WC_NS     = 35;          // write cycle time
    localparam int unsigned T_WP_NS     = 25;          // write pulse width
    localparam int unsigned T_DS_NS     = 15;          // data setup before end of write
    localparam int unsigned T_HZCE_NS   = 15;          // chip disable to output float
    // derived cycle counts; least times round up
    localparam int unsigned RC_CYC   = (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned AA_CYC   = (T_AA_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned WC_CYC   = (T_WC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned WP_CYC   = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned HZ_CYC   = (T_HZCE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned CNT_W    = 4;              // width of the phase counter
    localparam int unsigned SYNC_CYC = 2;              // cycles through the data synchroniser
    // reset values of the pins
    localparam logic        SEL_B_RST   = 1'b1;        // deselected
    localparam logic        WR_B_RST    = 1'b1;        // no write

    // user request
    typedef struct packed {
        logic              valid;                      // request present
        logic              write;                      // 1 write, 0 read
        logic [ADDR_W-1:0] addr;                       // cell address
        logic              wdata;                      // bit to store
    } asr_req_t;

    // pins toward the memory
    typedef struct packed {
        logic [ADDR_W-1:0] addr;                       // address pins
        logic              din;                        // write data pin
        logic              sel_b;                      // chip select, active low
        logic              wr_b;                       // write strobe, active low
    } asr_pins_t;

    // controller states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,                           // deselected, waiting
        ST_RSET  = 5'b00010,                           // address set up, then select
        ST_READ  = 5'b00100,                           // selected, waiting access time
        ST_WRITE = 5'b01000,                           // write strobe low
        ST_REC   = 5'b10000                            // recovery to end of cycle
    } asr_state_t;
endpackage
`default_nettype wire

// File: rtl/asr_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two flip-flop synchroniser for the memory's data output
module asr_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // data
    input  wire logic d,
    output logic      q
);
    logic meta_q;                                      // first stage, read only by second

    // two-stage capture
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: rtl/asr_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module asr_ctrl #(
    parameter int unsigned RC_CYC = asr_pkg::RC_CYC,   // read cycle, cycles
    parameter int unsigned AA_CYC = asr_pkg::AA_CYC,   // access time, cycles
    parameter int unsigned WC_CYC = asr_pkg::WC_CYC,   // write cycle, cycles
    parameter int unsigned WP_CYC = asr_pkg::WP_CYC    // write pulse, cycles
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // user side
    input  wire asr_pkg::asr_req_t req,
    output logic                  req_ready,
    output logic                  rd_valid,
    output logic                  rd_data,
    // retention control
    input  wire logic             retain_req,
    output logic                  retain_ok,
    // memory pins
    output asr_pkg::asr_pins_t    pins,
    input  wire logic             mem_dout
);
    // counter width and the top count it can hold before wrapping
    localparam int unsigned CW      = asr_pkg::CNT_W;      // phase counter width
    localparam int unsigned CNT_MAX = (1 << CW) - 1;       // largest count

    // elaboration checks: each phase needs at least one cycle, the read cycle two
    if (RC_CYC < 2 || AA_CYC < 1 || WP_CYC < 1) begin : g_bad_min
        $error("asr_ctrl: timing count below the least the sequence serves");
    end
    // the strobe must rise before the write cycle is over
    if (WC_CYC < WP_CYC + 1) begin : g_bad_wc
        $error("asr_ctrl: write cycle shorter than pulse plus release");
    end
    // the recovery compare adds one, so stay two below the wrap
    if (RC_CYC + 1 > CNT_MAX || AA_CYC + asr_pkg::SYNC_CYC + 2 > CNT_MAX) begin : g_bad_rd
        $error("asr_ctrl: read counts exceed the phase counter");
    end
    // same margin for the write pulse; the write cycle is only kept within the largest count
    if (WP_CYC + 2 > CNT_MAX || WC_CYC > CNT_MAX) begin : g_bad_wr
        $error("asr_ctrl: write counts exceed the phase counter");
    end

    // whole state of the controller
    typedef struct packed {
        asr_pkg::asr_state_t      st;                  // phase
        logic [asr_pkg::CNT_W-1:0] cnt;                // cycles spent in cycle
        asr_pkg::asr_pins_t       pins;                // pin drive
        logic                     rdy;                 // accept next request
        logic                     rv;                  // read result strobe
        logic                     rd;                  // read result bit
        logic                     ret;                 // safe to drop supply
        logic                     inc;                 // request is a write
    } asr_st_t;

    asr_st_t s_q;                                      // registered state
    asr_st_t s_d;                                      // next state
    logic    dout_s;                                   // synchronised memory data

    // synchronise the memory's output before use
    asr_sync u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .d     (mem_dout),
        .q     (dout_s)
    );

    // counts cut to the counter width on purpose; the checks above keep them in range
    // read cycle length, counted from the take edge
    localparam logic [CW-1:0] RC_L  = CW'(RC_CYC);
    // write pulse width, counted from the take edge
    localparam logic [CW-1:0] WP_L  = CW'(WP_CYC);
    // write cycle length, counted from the take edge
    localparam logic [CW-1:0] WC_L  = CW'(WC_CYC);
    // read sample point: access time plus the synchroniser's cycles
    localparam logic [CW-1:0] SMP_L = CW'(AA_CYC + asr_pkg::SYNC_CYC);
    // counter step
    localparam logic [CW-1:0] ONE_L = CW'(1);

    // next-state logic: one copy of the state, filled phase by phase
    always_comb begin
        // default: hold everything, drop the one-cycle strobe, count on
        s_d     = s_q;
        // read strobe lasts a single cycle
        s_d.rv  = 1'b0;
        // cycles since the request was taken
        s_d.cnt = s_q.cnt + ONE_L;
        case (s_q.st)
            // idle: memory deselected and in standby
            asr_pkg::ST_IDLE: begin
                // counter restarts so every phase is timed from the take edge
                s_d.cnt          = '0;
                // keep the memory deselected and the strobe off
                s_d.pins.sel_b   = 1'b1;
                s_d.pins.wr_b    = 1'b1;
                // retention granted only while idle and deselected
                s_d.ret          = retain_req;
                // no request accepted while retention is asked for
                s_d.rdy          = !retain_req;
                if (req.valid && s_q.rdy && !retain_req) begin
                    // request taken: busy until the cycle is padded out
                    s_d.rdy       = 1'b0;
                    s_d.ret       = 1'b0;
                    // address and data go out a cycle ahead of select
                    s_d.pins.addr = req.addr;
                    s_d.pins.din  = req.wdata;
                    if (req.write) begin
                        // select and strobe fall together one cycle later
                        s_d.st = asr_pkg::ST_RSET;
                        s_d.inc = 1'b1;
                    end else begin
                        // a read keeps the strobe high throughout
                        s_d.st  = asr_pkg::ST_RSET;
                        s_d.inc = 1'b0;
                    end
                end
            end
            // address is already stable; now select
            asr_pkg::ST_RSET: begin
                // select falls no earlier than the address settles
                s_d.pins.sel_b = 1'b0;
                if (s_q.inc) begin
                    // write window opens with select and strobe both low
                    s_d.pins.wr_b = 1'b0;
                    s_d.st        = asr_pkg::ST_WRITE;
                end else begin
                    // strobe high: the memory drives the addressed bit
                    s_d.pins.wr_b = 1'b1;
                    s_d.st        = asr_pkg::ST_READ;
                end
            end
            // selected read: wait access time, then capture
            asr_pkg::ST_READ: begin
                // sample once the access time and synchroniser have passed
                if (s_q.cnt == SMP_L) begin
                    s_d.rv = 1'b1;
                    // an unwritten cell's unknown passes through unchanged
                    s_d.rd = dout_s;
                end
                // deselect no earlier than the sample edge and the least read cycle
                if (s_q.cnt >= SMP_L && s_q.cnt + ONE_L >= RC_L) begin
                    s_d.pins.sel_b = 1'b1;
                    s_d.st         = asr_pkg::ST_REC;
                end
            end
            // write strobe held for the pulse width, address frozen
            asr_pkg::ST_WRITE: begin
                // data and address steady since the take, select since it fell with the strobe
                if (s_q.cnt >= WP_L) begin
                    // close the window; address stays put past its end
                    s_d.pins.wr_b  = 1'b1;
                    s_d.pins.sel_b = 1'b1;
                    s_d.st         = asr_pkg::ST_REC;
                end
            end
            // pad out the cycle, leave address unchanged
            asr_pkg::ST_REC: begin
                // writes and reads each wait out their own cycle time
                if (s_q.cnt + ONE_L >= (s_q.inc ? WC_L : RC_L)) begin
                    s_d.st  = asr_pkg::ST_IDLE;
                    // stay busy if retention is waiting to be granted
                    s_d.rdy = !retain_req;
                end
            end
            // illegal code: recover to idle, pins follow on the next pass
            default: begin
                s_d.st = asr_pkg::ST_IDLE;
            end
        endcase
    end

    // state register; reset leaves the memory deselected with no write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            // everything cleared, then the active-low pins set inactive
            s_q            <= '0;
            s_q.st         <= asr_pkg::ST_IDLE;
            s_q.pins.sel_b <= asr_pkg::SEL_B_RST;
            s_q.pins.wr_b  <= asr_pkg::WR_B_RST;
        end else begin
            // every field moves on every edge
            s_q <= s_d;
        end
    end

    // outputs straight from the state register, no logic after the flops
    assign pins      = s_q.pins;
    assign req_ready = s_q.rdy;
    assign rd_valid  = s_q.rv;
    assign rd_data   = s_q.rd;
    assign retain_ok = s_q.ret;
endmodule
`default_nettype wire

// File: verif/asr_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// behavioural one-bit memory on the far side of the pins
module asr_mem_model (
    // memory pins
    input  wire asr_pkg::asr_pins_t pins,
    output logic                    dout
);
    logic cell_q [0:65535];              // unwritten cells stay unknown
    initial dout = 1'b0;
    // store, drive or release on every pin change; float shows the inverse, never the old bit
    always @(pins) begin
        if (!pins.sel_b && !pins.wr_b) begin
            cell_q[pins.addr] = pins.din;
            dout <= #6 ~dout;
        end else if (!pins.sel_b) begin
            dout <= #25 cell_q[pins.addr];
        end else begin
            dout <= #15 ~dout;
        end
    end
endmodule
`default_nettype wire

// File: verif/asr_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
// pin and handshake checks beside the controller
module asr_ctrl_sva (
    // clock and reset
    input wire logic               clock,
    input wire logic               rst_b,
    // user side
    input wire asr_pkg::asr_req_t  req,
    input wire logic               req_ready,
    input wire logic               rd_valid,
    input wire logic               rd_data,
    input wire logic               retain_req,
    input wire logic               retain_ok,
    // memory pins
    input wire asr_pkg::asr_pins_t pins,
    input wire logic               mem_dout
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // a read request taken at this edge
    wire take_rd = req.valid && req_ready && !req.write && !retain_req;
    strobe_sel_a: assert property (!pins.wr_b |-> !pins.sel_b)
        else $error("strobe low while deselected");
    addr_hold_a: assert property (!pins.wr_b && !$past(pins.wr_b) |-> $stable(pins.addr))
        else $error("address moved inside write window");
    pulse_width_a: assert property ($fell(pins.wr_b) |-> (!pins.wr_b && $stable(pins.din)) [*3])
        else $error("write pulse short or data moved");
    addr_setup_a: assert property ($fell(pins.sel_b) |-> $stable(pins.addr))
        else $error("address not set before select");
    write_cycle_a: assert property ($fell(pins.wr_b) |-> ##1 (!$fell(pins.sel_b)) [*4])
        else $error("write cycle too short");
    read_cycle_a: assert property ($fell(pins.sel_b) && pins.wr_b |-> ##1 (!$fell(pins.sel_b)) [*5])
        else $error("read cycle too short");
    read_latency_a: assert property (take_rd |-> ##1 (!rd_valid) [*7] ##1 rd_valid ##1 !rd_valid)
        else $error("read answer at wrong cycle");
    retain_idle_a: assert property (retain_ok |-> pins.sel_b && pins.wr_b && !req_ready)
        else $error("retention granted while selected");
    // main scenarios reached
    cover property (take_rd ##8 rd_valid);
    cover property ($fell(pins.wr_b));
    cover property ($rose(retain_ok));
endmodule
bind asr_ctrl asr_ctrl_sva u_asr_ctrl_sva (.clock(clock), .rst_b(rst_b), .req(req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .retain_req(retain_req),
    .retain_ok(retain_ok), .pins(pins), .mem_dout(mem_dout));
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic               clock = 1'b0;     // 100 MHz
    logic               rst_b = 1'b0;     // reset, active low
    asr_pkg::asr_req_t  req = '0;         // user request
    logic               retain_req = 1'b0; // retention ask
    logic               req_ready, rd_valid, rd_data, retain_ok, mem_dout;
    asr_pkg::asr_pins_t pins;              // controller to memory
    int                 n_errors = 0;
    int                 tests_run = 0;
    int                 cyc = 0;
    asr_ctrl u_asr_ctrl (.clock(clock), .rst_b(rst_b), .req(req), .req_ready(req_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .retain_req(retain_req),
        .retain_ok(retain_ok), .pins(pins), .mem_dout(mem_dout));
    asr_mem_model u_mem (.pins(pins), .dout(mem_dout));
    always #5 clock = ~clock;
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    // one request; a read is judged on its answer and its latency
    task automatic op(input logic wr, input logic [15:0] a, input logic d, input logic exp);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(posedge clock); #1; n++;
        end
        req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge clock); #1;
        req.valid = 1'b0;
        check(req_ready, 1'b0);
        if (!wr) begin
            n = 0;
            while (rd_valid !== 1'b1 && n < 20) begin
                @(posedge clock); #1; n++;
            end
            check(rd_data, exp);
            check(n == asr_pkg::AA_CYC + asr_pkg::SYNC_CYC + 1, 1'b1);
        end
    endtask
    // pins idle while reset holds
    task automatic t_reset();
        check(pins.sel_b, 1'b1);
        check(pins.wr_b, 1'b1);
        check(req_ready, 1'b0);
        $display("test reset done");
    endtask
    // boundary cells, back to back, overwrite, unwritten cell
    task automatic t_rw();
        op(1'b1, 16'h0000, 1'b1, 1'b0);
        op(1'b1, 16'hffff, 1'b0, 1'b0);
        op(1'b0, 16'h0000, 1'b0, 1'b1);
        op(1'b0, 16'hffff, 1'b0, 1'b0);
        op(1'b1, 16'h0000, 1'b0, 1'b0);
        op(1'b0, 16'h0000, 1'b0, 1'b0);
        op(1'b0, 16'h1234, 1'b0, 1'bx);
        $display("test read write done");
    endtask
    // retention: deselected, requests refused, nothing stored
    task automatic t_retain();
        int n;
        retain_req = 1'b1;
        n = 0;
        while (retain_ok !== 1'b1 && n < 20) begin
            @(posedge clock); #1; n++;
        end
        check(retain_ok, 1'b1);
        req = '{valid: 1'b1, write: 1'b1, addr: 16'hffff, wdata: 1'b1};
        repeat (4) begin
            @(posedge clock); #1;
            check(pins.sel_b, 1'b1);
        end
        req.valid = 1'b0;
        retain_req = 1'b0;
        op(1'b0, 16'hffff, 1'b0, 1'b0);
        $display("test retention done");
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        #1;
        t_reset();
        rst_b = 1'b1;
        t_rw();
        t_retain();
        finish_test();
    end
endmodule
`default_nettype wire
